// *** src/mfc_pkg.sv ***
// Package of constants and types for the metering front end control block.
package mfc_pkg;
  // Register indices; the AXI byte address is four times the index.
  localparam logic [13:0] IDX_SENSOR_CMD = 14'h00FC;
  localparam logic [13:0] IDX_SLOT_BASE = 14'h2100;
  localparam logic [13:0] IDX_SLOT_LAST = 14'h2105;
  localparam logic [13:0] IDX_EQU_CHOP = 14'h2106;
  localparam logic [13:0] IDX_FILTER_CFG = 14'h210C;
  localparam logic [13:0] IDX_RD_HIGH = 14'h2602;
  localparam logic [13:0] IDX_RD_LOW = 14'h2603;
  localparam logic [13:0] IDX_LINK6_SEL = 14'h2709;
  localparam logic [13:0] IDX_LINK24_SEL = 14'h270A;
  // Field positions and counts.
  localparam int CHOP_LSB = 2;
  localparam int DEC_LEN_LSB = 1;
  localparam int LINK_EN_LSB = 3;
  localparam int LINK6_SEL_LSB = 0;
  localparam int LINK2_SEL_LSB = 0;
  localparam int LINK4_SEL_LSB = 4;
  localparam int CMD_CODE_LSB = 2;
  localparam int PERR_WR_BIT = 5;
  localparam int READ_PARITY_ERR_BIT = 6;
  localparam int RESULT_SHIFT = 9;
  localparam int NUM_SLOTS = 11;
  localparam int NUM_LINKS = 3;
  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] RD_BUF_RESET = 16'h0000;
  // Codes.
  localparam logic [1:0] DEC_LEN_21 = 2'h1;
  localparam logic [1:0] CHOP_AUTO = 2'h0;
  localparam logic [1:0] CHOP_LOW = 2'h1;
  localparam logic [1:0] CHOP_HIGH = 2'h2;
  localparam logic [1:0] CHOP_AUTO_HOLD = 2'h3;
  localparam logic [2:0] CMD_ONE = 3'h1;
  localparam logic [2:0] CMD_TWO = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // First engine RAM word for remote link results; link n writes this word plus n.
  localparam logic [9:0] REMOTE_RAM_BASE = 10'h010;

  typedef enum logic [1:0] {SEQ_SLOTS, SEQ_WAIT_EDGE, SEQ_SETTLE} seq_state_t;

  typedef struct packed {
    logic we;
    logic [9:0] addr;
    logic [31:0] data;
  } ram_wr_t;

  typedef struct packed {
    logic valid;
    logic [2:0] code;
    logic [1:0] link;
    logic [2:0] sel;
  } link_req_t;

  typedef struct packed {
    logic aw_full;
    logic [13:0] aw_idx;
    logic w_full;
    logic [7:0] wdata;
    logic wbyte;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic [5:0][7:0] slot_regs;
    logic [7:0] equ_chop;
    logic [7:0] filter_cfg;
    logic [7:0] link6_sel;
    logic [7:0] link24_sel;
    logic [4:0] cmd;
    logic read_parity_err;
    logic perr_wr;
    logic [15:0] rd_buf;
    logic busy;
    link_req_t req;
    seq_state_t seq;
    logic [3:0] slot;
    logic [3:0] slot_in;
    logic swap;
    logic fsync;
    logic eng_start;
    ram_wr_t ram;
    logic [2:0] pend;
    logic [2:0][21:0] pend_data;
  } state_t;
endpackage

// *** src/metering_frontend_control.sv ***
// Converter sequencing, reference chopping and remote sensor command engine.
//
// How it works
// - Results are 21 bits signed for length select 01, 22 bits for 10.
// - Each conversion result goes to engine RAM at the slot's input handle.
// - Every result is shifted left nine places before the RAM write.
// - After the last slot, first slow edge starts one extra slow cycle.
// - The reference swap is updated at the start of the extra cycle.
// - Frame sync is high throughout the extra settling cycle.
// - Rising edge of frame sync starts one engine program pass.
// - Chop mode 01 holds swap low, 10 holds swap high.
// - Chop mode 00 toggles swap every frame without software help.
// - Chop mode 11 toggles but skips the last frame of an accumulation.
// - Link enable bits turn three input pairs into remote sensor links.
// - Results from each enabled remote link are written to engine RAM.
// - Read completion clears the command code bits, keeps the link bits and fills the read buffer.
// - The read parity error flag is set by any remote read that reports a parity error.
// - Command writes during a read in progress are ignored.
// - Command codes 001 and 010 are valid; others are ignored.
// - Link selector 01, 10, 11 picks links 2, 4, 6; 00 is invalid.
// - Parity error flags stay set until software writes them clear.
`timescale 1ns/1ps
`default_nettype none
module metering_frontend_control
  import mfc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [15:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [15:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic SLOW_TICK,
  input wire logic CONV_DONE,
  input wire logic [21:0] CONV_DATA,
  output logic [3:0] SLOT_INPUT,
  input wire logic ACCUM_LAST,
  output logic REFERENCE_SWAP,
  output logic FRAME_SYNC,
  output logic ENGINE_START,
  output ram_wr_t RAM_WR,
  input wire logic [2:0] REMOTE_VALID,
  input wire logic [2:0][21:0] REMOTE_DATA,
  output logic [2:0] REMOTE_LINK_EN,
  output link_req_t LINK_REQ,
  input wire logic LINK_DONE,
  input wire logic [15:0] LINK_DATA,
  input wire logic LINK_PERR
);
  state_t s_q, s_d;

  function automatic logic [3:0] slot_field(input logic [5:0][7:0] r, input logic [3:0] k);
    logic [3:0] idx;
    idx = 4'(4'd5 - (k >> 1));
    slot_field = k[0] ? r[idx[2:0]][7:4] : r[idx[2:0]][3:0];
  endfunction

  function automatic logic [31:0] scale(input logic [21:0] v, input logic len21);
    logic [31:0] ext;
    ext = len21 ? {{11{v[20]}}, v[20:0]} : {{10{v[21]}}, v};
    scale = ext << RESULT_SHIFT;
  endfunction

  logic [7:0] strb_byte;
  logic aw_hit, w_hit, ar_hit, wr_go;
  logic [13:0] ar_idx;
  logic [3:0] frame_slots;
  logic [2:0] link_en;
  logic [2:0] sel_for_link;
  logic len21;
  logic [1:0] chop;

  assign ar_idx = ARADDR[15:2];
  assign frame_slots = s_q.slot_regs[0][7:4];
  assign link_en = s_q.link6_sel[LINK_EN_LSB +: NUM_LINKS];
  assign len21 = s_q.filter_cfg[DEC_LEN_LSB +: 2] == DEC_LEN_21;
  assign chop = s_q.equ_chop[CHOP_LSB +: 2];
  assign strb_byte = WDATA[7:0];

  always_comb begin
    unique case (s_q.cmd[1:0])
      2'h1: sel_for_link = s_q.link24_sel[LINK2_SEL_LSB +: 3];
      2'h2: sel_for_link = s_q.link24_sel[LINK4_SEL_LSB +: 3];
      default: sel_for_link = s_q.link6_sel[LINK6_SEL_LSB +: 3];
    endcase
  end

  always_comb begin
    s_d = s_q;
    aw_hit = AWVALID && !s_q.aw_full && !s_q.bvalid;
    w_hit = WVALID && !s_q.w_full && !s_q.bvalid;
    ar_hit = ARVALID && !s_q.rvalid;
    wr_go = 1'b0;
    s_d.req.valid = 1'b0;
    s_d.eng_start = 1'b0;
    s_d.ram.we = 1'b0;

    // Write address and data are taken in either order.
    if (aw_hit) begin
      s_d.aw_full = 1'b1;
      s_d.aw_idx = AWADDR[15:2];
    end
    if (w_hit) begin
      s_d.w_full = 1'b1;
      s_d.wdata = strb_byte;
      s_d.wbyte = WSTRB[0];
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_full && s_q.w_full) begin
      wr_go = s_q.wbyte;
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (s_q.aw_idx >= IDX_SLOT_BASE && s_q.aw_idx <= IDX_SLOT_LAST) begin
        if (wr_go) begin
          s_d.slot_regs[3'(s_q.aw_idx - IDX_SLOT_BASE)] = s_q.wdata;
        end
      end else begin
        case (s_q.aw_idx)
          IDX_SENSOR_CMD: begin
            if (wr_go) begin
              s_d.read_parity_err = s_q.read_parity_err & s_q.wdata[READ_PARITY_ERR_BIT];
              s_d.perr_wr = s_q.perr_wr & s_q.wdata[PERR_WR_BIT];
            end
            if (wr_go && !s_q.busy && s_q.wdata[1:0] != 2'h0 &&
                (s_q.wdata[4:2] == CMD_ONE || s_q.wdata[4:2] == CMD_TWO)) begin
              s_d.cmd = s_q.wdata[4:0];
            end
          end
          IDX_EQU_CHOP: if (wr_go) s_d.equ_chop = s_q.wdata;
          IDX_FILTER_CFG: if (wr_go) s_d.filter_cfg = s_q.wdata;
          IDX_LINK6_SEL: if (wr_go) s_d.link6_sel = s_q.wdata;
          IDX_LINK24_SEL: if (wr_go) s_d.link24_sel = s_q.wdata;
          IDX_RD_HIGH, IDX_RD_LOW: s_d.bresp = RESP_OKAY;
          default: s_d.bresp = RESP_SLVERR;
        endcase
      end
    end

    // Reads answer one cycle after the address is taken.
    if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_hit) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 8'h00;
      if (ar_idx >= IDX_SLOT_BASE && ar_idx <= IDX_SLOT_LAST) begin
        s_d.rdata = s_q.slot_regs[3'(ar_idx - IDX_SLOT_BASE)];
      end else begin
        case (ar_idx)
          IDX_SENSOR_CMD: s_d.rdata = {1'b0, s_q.read_parity_err, s_q.perr_wr, s_q.cmd};
          IDX_EQU_CHOP: s_d.rdata = s_q.equ_chop;
          IDX_FILTER_CFG: s_d.rdata = s_q.filter_cfg;
          IDX_RD_HIGH: s_d.rdata = s_q.rd_buf[15:8];
          IDX_RD_LOW: s_d.rdata = s_q.rd_buf[7:0];
          IDX_LINK6_SEL: s_d.rdata = s_q.link6_sel;
          IDX_LINK24_SEL: s_d.rdata = s_q.link24_sel;
          default: s_d.rresp = RESP_SLVERR;
        endcase
      end
    end

    // request launched with the select field current at command time
    if (s_q.cmd[4:2] != 3'h0 && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.req.valid = 1'b1;
      s_d.req.code = s_q.cmd[4:2];
      s_d.req.link = s_q.cmd[1:0];
      s_d.req.sel = sel_for_link;
    end
    if (s_q.busy && LINK_DONE) begin
      s_d.busy = 1'b0;
      s_d.cmd[4:2] = 3'h0;
      s_d.rd_buf = LINK_DATA;
      s_d.read_parity_err = s_d.read_parity_err | LINK_PERR;
    end

    // Slot sequencer.
    case (s_q.seq)
      SEQ_SLOTS: begin
        if (CONV_DONE) begin
          // store scaled result at the slot's handle
          s_d.ram.we = 1'b1;
          s_d.ram.addr = {6'h00, s_q.slot_in};
          s_d.ram.data = scale(CONV_DATA, len21);
          if (s_q.slot + 4'h1 >= frame_slots) begin
            s_d.seq = SEQ_WAIT_EDGE;
          end else begin
            s_d.slot = s_q.slot + 4'h1;
          end
        end
      end
      SEQ_WAIT_EDGE: begin
        // first slow edge opens the settling cycle
        if (SLOW_TICK) begin
          s_d.seq = SEQ_SETTLE;
          s_d.fsync = 1'b1;
          s_d.eng_start = 1'b1;
          case (chop)
            CHOP_LOW: s_d.swap = 1'b0;
            CHOP_HIGH: s_d.swap = 1'b1;
            CHOP_AUTO: s_d.swap = !s_q.swap;
            // no toggle on the accumulation's last frame
            CHOP_AUTO_HOLD: s_d.swap = ACCUM_LAST ? s_q.swap : !s_q.swap;
            default: s_d.swap = s_q.swap;
          endcase
        end
      end
      SEQ_SETTLE: begin
        if (SLOW_TICK) begin
          s_d.seq = SEQ_SLOTS;
          s_d.fsync = 1'b0;
          s_d.slot = 4'h0;
        end
      end
      default: s_d.seq = SEQ_SLOTS;
    endcase
    // The handle tracks the new slot at once, so a prompt result lands at the right word.
    s_d.slot_in = slot_field(s_d.slot_regs, s_d.slot);

    // remote results wait for a free RAM slot
    for (int n = 0; n < NUM_LINKS; n++) begin
      if (REMOTE_VALID[n] && link_en[n]) begin
        s_d.pend[n] = 1'b1;
        s_d.pend_data[n] = REMOTE_DATA[n];
      end
    end
    if (!s_d.ram.we) begin
      for (int n = NUM_LINKS - 1; n >= 0; n--) begin
        if (s_q.pend[n] && !s_d.ram.we) begin
          s_d.ram.we = 1'b1;
          s_d.ram.addr = REMOTE_RAM_BASE + 10'(n);
          s_d.ram.data = scale(s_q.pend_data[n], len21);
          s_d.pend[n] = REMOTE_VALID[n] && link_en[n];
        end
      end
    end
    // Bus readies are registered so every port comes from a flip-flop.
    s_d.aw_rdy = !s_d.aw_full && !s_d.bvalid;
    s_d.w_rdy = !s_d.w_full && !s_d.bvalid;
    s_d.ar_rdy = !s_d.rvalid;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_q <= '0;
      s_q.seq <= SEQ_SLOTS;
      s_q.rd_buf <= RD_BUF_RESET;
      s_q.equ_chop <= REG_RESET;
      s_q.aw_rdy <= 1'b1;
      s_q.w_rdy <= 1'b1;
      s_q.ar_rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign AWREADY = s_q.aw_rdy;
  assign WREADY = s_q.w_rdy;
  assign BVALID = s_q.bvalid;
  assign BRESP = s_q.bresp;
  assign ARREADY = s_q.ar_rdy;
  assign RVALID = s_q.rvalid;
  assign RDATA = {24'h000000, s_q.rdata};
  assign RRESP = s_q.rresp;
  assign SLOT_INPUT = s_q.slot_in;
  assign REFERENCE_SWAP = s_q.swap;
  assign FRAME_SYNC = s_q.fsync;
  assign ENGINE_START = s_q.eng_start;
  assign RAM_WR = s_q.ram;
  assign REMOTE_LINK_EN = link_en;
  assign LINK_REQ = s_q.req;

  // sync stays high until the closing slow edge
  property p_sync_hold;
    @(posedge CLK_SYS) disable iff (RST)
      FRAME_SYNC && !SLOW_TICK |=> FRAME_SYNC;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync dropped early");

  // one start pulse per sync rise
  property p_start;
    @(posedge CLK_SYS) disable iff (RST) $rose(FRAME_SYNC) |-> ENGINE_START ##1 !ENGINE_START;
  endproperty
  a_start: assert property (p_start) else $error("engine start missing");

  property p_chop_fixed;
    @(posedge CLK_SYS) disable iff (RST)
      $rose(FRAME_SYNC) && $past(chop) == CHOP_HIGH |-> REFERENCE_SWAP;
  endproperty
  a_chop_fixed: assert property (p_chop_fixed) else $error("swap not high");

  property p_chop_low;
    @(posedge CLK_SYS) disable iff (RST)
      $rose(FRAME_SYNC) && $past(chop) == CHOP_LOW |-> !REFERENCE_SWAP;
  endproperty
  a_chop_low: assert property (p_chop_low) else $error("swap not low");

  // auto mode toggles at the sync rise
  property p_chop_auto;
    @(posedge CLK_SYS) disable iff (RST)
      $rose(FRAME_SYNC) && $past(chop) == CHOP_AUTO |-> REFERENCE_SWAP != $past(REFERENCE_SWAP);
  endproperty
  a_chop_auto: assert property (p_chop_auto) else $error("swap not toggled");

  // held on the accumulation's last frame
  property p_chop_hold;
    @(posedge CLK_SYS) disable iff (RST)
      $rose(FRAME_SYNC) && $past(chop) == CHOP_AUTO_HOLD && $past(ACCUM_LAST)
      |-> $stable(REFERENCE_SWAP);
  endproperty
  a_chop_hold: assert property (p_chop_hold) else $error("swap toggled");

  // converter write lands at the slot handle, shifted
  property p_ram_write;
    @(posedge CLK_SYS) disable iff (RST)
      CONV_DONE && s_q.seq == SEQ_SLOTS |=> RAM_WR.we && RAM_WR.addr[3:0] == $past(SLOT_INPUT)
      && RAM_WR.data[8:0] == 9'h000;
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("bad result write");

  // completion clears command code within one cycle
  property p_done;
    @(posedge CLK_SYS) disable iff (RST)
      s_q.busy && LINK_DONE |=> s_q.cmd[4:2] == 3'h0 && s_q.rd_buf == $past(LINK_DATA);
  endproperty
  a_done: assert property (p_done) else $error("completion not applied");

  property p_buf_hold;
    @(posedge CLK_SYS) disable iff (RST) !(s_q.busy && LINK_DONE) |=> $stable(s_q.rd_buf);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("read buffer changed");

  property p_busy_ignore;
    @(posedge CLK_SYS) disable iff (RST) s_q.busy && !LINK_DONE |=> $stable(s_q.cmd);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("command changed while busy");

  property p_perr;
    @(posedge CLK_SYS) disable iff (RST) s_q.busy && LINK_DONE && LINK_PERR |=> ##[0:1] s_q.read_parity_err;
  endproperty
  a_perr: assert property (p_perr) else $error("parity flag not set");

  // only valid codes and links go out
  property p_req_code;
    @(posedge CLK_SYS) disable iff (RST)
      LINK_REQ.valid |-> LINK_REQ.link != 2'h0
      && (LINK_REQ.code == CMD_ONE || LINK_REQ.code == CMD_TWO);
  endproperty
  a_req_code: assert property (p_req_code) else $error("invalid link request");
endmodule
`default_nettype wire

// *** test/remote_sensor_model.sv ***
// Behavioural model of the remote current sensors behind the links.
`timescale 1ns/1ps
`default_nettype none
module remote_sensor_model
  import mfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire link_req_t req,
  input wire logic [2:0] en,
  input wire logic [15:0] rdat,
  input wire logic rpe,
  input wire logic [7:0] dly,
  input wire logic [2:0] fire,
  input wire logic [21:0] fdat,
  output logic done,
  output logic [15:0] data,
  output logic pe,
  output logic [2:0] sv,
  output logic [2:0][21:0] sd
);
  logic busy;
  logic [7:0] cnt;
  // Answer lines toggle between answers so a stale value never matches.
  always_ff @(posedge clk) begin
    done <= 1'b0;
    data <= ~data;
    pe <= ~pe;
    if (rst) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      data <= 16'h0000;
      pe <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h00) begin
        busy <= 1'b0;
        done <= 1'b1;
        data <= rdat;
        pe <= rpe;
      end
    end else if (req.valid) begin
      busy <= 1'b1;
      cnt <= dly;
    end
  end
  always_ff @(posedge clk) begin
    sv <= fire & en;
    for (int i = 0; i < 3; i++) begin
      sd[i] <= rst ? 22'h000000 : (fire[i] ? fdat : ~sd[i]);
    end
  end
endmodule
`default_nettype wire

// *** test/metering_frontend_control_tb.sv ***
// Self-checking bench for the metering front end control block.
`timescale 1ns/1ps
`default_nettype none
module metering_frontend_control_tb;
  import mfc_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLOW_TICK, CONV_DONE, ACCUM_LAST;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, REFERENCE_SWAP, FRAME_SYNC, ENGINE_START;
  logic [15:0] AWADDR, ARADDR, LINK_DATA, rdat;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0] WSTRB, SLOT_INPUT;
  logic [1:0] BRESP, RRESP, rsp;
  logic [21:0] CONV_DATA, fdat, v;
  ram_wr_t RAM_WR, w;
  logic [2:0] REMOTE_VALID, REMOTE_LINK_EN, fire;
  logic [2:0][21:0] REMOTE_DATA;
  link_req_t LINK_REQ;
  logic LINK_DONE, LINK_PERR, rpe, w21, swp, pe_e;
  logic [7:0] dly, b;
  logic [3:0] sin[3];
  logic [2:0] sel[4];
  logic [13:0] regs[7] = '{IDX_SENSOR_CMD, IDX_EQU_CHOP, IDX_FILTER_CFG, IDX_RD_HIGH,
    IDX_RD_LOW, IDX_LINK6_SEL, IDX_LINK24_SEL};
  logic [4:0] bad[3] = '{5'h01, 5'h16, 5'h04};
  int err_count = 0;
  int n_tests = 0;
  ram_wr_t ram_q[$];
  link_req_t req_q[$];
  metering_frontend_control u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
    .RRESP(RRESP), .SLOW_TICK(SLOW_TICK), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
    .SLOT_INPUT(SLOT_INPUT), .ACCUM_LAST(ACCUM_LAST), .REFERENCE_SWAP(REFERENCE_SWAP),
    .FRAME_SYNC(FRAME_SYNC), .ENGINE_START(ENGINE_START), .RAM_WR(RAM_WR),
    .REMOTE_VALID(REMOTE_VALID), .REMOTE_DATA(REMOTE_DATA), .REMOTE_LINK_EN(REMOTE_LINK_EN),
    .LINK_REQ(LINK_REQ), .LINK_DONE(LINK_DONE), .LINK_DATA(LINK_DATA), .LINK_PERR(LINK_PERR));
  remote_sensor_model u_far (.clk(CLK_SYS), .rst(RST), .req(LINK_REQ), .en(REMOTE_LINK_EN),
    .rdat(rdat), .rpe(rpe), .dly(dly), .fire(fire), .fdat(fdat), .done(LINK_DONE),
    .data(LINK_DATA), .pe(LINK_PERR), .sv(REMOTE_VALID), .sd(REMOTE_DATA));
  always #25 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    if (RAM_WR.we === 1'b1) ram_q.push_back(RAM_WR);
    if (LINK_REQ.valid === 1'b1) req_q.push_back(LINK_REQ);
  end
  function automatic logic [31:0] xram(input logic [21:0] d, input logic n21);
    logic [31:0] s;
    s = n21 ? {{11{d[20]}}, d[20:0]} : {{10{d[21]}}, d};
    return s << RESULT_SHIFT;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [13:0] idx, input logic [7:0] d);
    logic aw, wd;
    aw = 1'b0;
    wd = 1'b0;
    @(posedge CLK_SYS);
    AWVALID <= 1'b1;
    AWADDR <= {idx, 2'h0};
    WVALID <= 1'b1;
    WDATA <= {24'($urandom), d};
    WSTRB <= 4'h1 | 4'($urandom);
    BREADY <= 1'b1;
    while (!(aw && wd)) begin
      @(posedge CLK_SYS);
      if (!aw && AWREADY === 1'b1) begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!wd && WREADY === 1'b1) begin
        wd = 1'b1;
        WVALID <= 1'b0;
      end
    end
    do @(posedge CLK_SYS); while (BVALID !== 1'b1);
    rsp = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic axi_rd(input logic [13:0] idx);
    @(posedge CLK_SYS);
    ARVALID <= 1'b1;
    ARADDR <= {idx, 2'h0};
    RREADY <= 1'b1;
    do @(posedge CLK_SYS); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge CLK_SYS); while (RVALID !== 1'b1);
    rd = RDATA | {RRESP, 30'h0};
    RREADY <= 1'b0;
  endtask
  task automatic ram_pop();
    int g;
    g = 0;
    do begin
      @(posedge CLK_SYS);
      #1;
      g++;
    end while (ram_q.size() == 0 && g < 20);
    w = (ram_q.size() > 0) ? ram_q.pop_front() : '1;
  endtask
  task automatic tick();
    @(posedge CLK_SYS);
    SLOW_TICK <= 1'b1;
    @(posedge CLK_SYS);
    SLOW_TICK <= 1'b0;
    #1;
  endtask
  task automatic run_frame(input logic [1:0] m, input logic last);
    ACCUM_LAST <= last;
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 22'h3FFFFF : 22'($urandom);
      chk("slot_input", {28'h0, sin[k]}, {28'h0, SLOT_INPUT});
      @(posedge CLK_SYS);
      CONV_DONE <= 1'b1;
      CONV_DATA <= v;
      @(posedge CLK_SYS);
      CONV_DONE <= 1'b0;
      CONV_DATA <= ~v;
      ram_pop();
      chk("ram_addr", {28'h0, sin[k]}, {22'h0, w.addr});
      chk("ram_data", xram(v, w21), w.data);
    end
    repeat ($urandom_range(4, 1)) @(posedge CLK_SYS);
    chk("wait_edge", 32'h0, {31'h0, FRAME_SYNC});
    swp = (m == CHOP_LOW) ? 1'b0 : (m == CHOP_HIGH) ? 1'b1 : (m == CHOP_AUTO_HOLD && last) ?
      swp : ~swp;
    tick();
    chk("sync_start", 32'h3, {30'h0, ENGINE_START, FRAME_SYNC});
    chk("swap", {31'h0, swp}, {31'h0, REFERENCE_SWAP});
    @(posedge CLK_SYS);
    #1;
    chk("settle", 32'h1, {30'h0, ENGINE_START, FRAME_SYNC});
    tick();
    chk("frame_end", 32'h0, {30'h0, ENGINE_START, FRAME_SYNC});
  endtask
  task automatic remote_read(input logic [2:0] c, input logic [1:0] l, input logic p,
    input logic intr);
    int g;
    b = 8'($urandom);
    rdat <= {b, ~b};
    rpe <= p;
    dly <= intr ? 8'h50 : 8'($urandom_range(30, 0));
    chk("engine_idle", 32'h0, {31'h0, FRAME_SYNC});
    axi_wr(IDX_SENSOR_CMD, {3'h3, c, l});
    if (intr) axi_wr(IDX_SENSOR_CMD, {3'h3, CMD_TWO, 2'h3});
    g = 0;
    do begin
      axi_rd(IDX_SENSOR_CMD);
      g++;
    end while (rd[4:2] !== 3'h0 && g < 100);
    pe_e = pe_e | p;
    chk("req_count", 32'h1, 32'(req_q.size()));
    chk("link_req", {23'h0, 1'b1, c, l, sel[l]}, {23'h0, req_q.pop_front()});
    chk("cmd_reg", {25'h0, pe_e, 4'h0, l}, rd);
    axi_rd(IDX_RD_HIGH);
    chk("rd_high", {24'h0, b}, rd);
    axi_rd(IDX_RD_LOW);
    chk("rd_low", {24'h0, ~b}, rd);
  endtask
  initial begin
    {RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLOW_TICK, CONV_DONE, ACCUM_LAST} = 9'h100;
    {AWADDR, ARADDR, WDATA, WSTRB, CONV_DATA, fdat, fire, rdat, rpe, dly} = '0;
    {swp, pe_e} = 2'h0;
    void'($urandom(46));
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    foreach (regs[i]) begin
      axi_rd(regs[i]);
      chk("reset_value", 32'h0, rd);
    end
    axi_wr(14'h0001, 8'h5A);
    chk("unmapped_wr", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    axi_rd(14'h0001);
    chk("unmapped_rd", {RESP_SLVERR, 30'h0}, rd);
    axi_wr(IDX_RD_LOW, 8'hA5);
    axi_rd(IDX_RD_LOW);
    chk("read_only", {RESP_OKAY, 30'h0}, rd | {rsp, 30'h0});
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      if (i == 0) b = {b[7:6], 3'h7, b[2:0]};
      axi_wr(i == 0 ? IDX_LINK6_SEL : IDX_LINK24_SEL, b);
      axi_rd(i == 0 ? IDX_LINK6_SEL : IDX_LINK24_SEL);
      chk("rw_readback", {24'h0, b}, rd);
    end
    sel[1] = b[2:0];
    sel[2] = b[6:4];
    axi_rd(IDX_LINK6_SEL);
    sel[3] = rd[2:0];
    chk("link_en", 32'h7, {29'h0, REMOTE_LINK_EN});
    v = 22'($urandom) & 22'h07FFFF;
    fdat <= v;
    fire <= 3'h7;
    @(posedge CLK_SYS);
    fire <= 3'h0;
    for (int i = 0; i < 3; i++) begin
      ram_pop();
      chk("remote_addr", {22'h0, REMOTE_RAM_BASE + 10'(2 - i)}, {22'h0, w.addr});
      chk("remote_data", xram(v, 1'b0), w.data);
    end
    for (int l = 1; l < 4; l++) begin
      for (int c = 1; c < 3; c++) begin
        remote_read(3'(c), 2'(l), l == 1 && c == 1, l == 2 && c == 2);
      end
    end
    foreach (bad[i]) begin
      axi_wr(IDX_SENSOR_CMD, {3'h3, bad[i]});
    end
    repeat (40) @(posedge CLK_SYS);
    chk("bad_cmd", 32'h0, 32'(req_q.size()));
    axi_rd(IDX_RD_HIGH);
    chk("buf_held", {24'h0, b}, rd);
    axi_wr(IDX_SENSOR_CMD, 8'h00);
    axi_rd(IDX_SENSOR_CMD);
    chk("perr_clear", 32'h0, {30'h0, rd[6:5]});
    foreach (sin[k]) sin[k] = 4'($urandom_range(10, 0));
    axi_wr(IDX_SLOT_BASE, 8'h30);
    axi_wr(IDX_SLOT_LAST, {sin[1], sin[0]});
    axi_wr(IDX_SLOT_LAST - 14'h0001, {4'h0, sin[2]});
    for (int n = 1; n >= 0; n--) begin
      w21 = 1'(n);
      axi_wr(IDX_FILTER_CFG, w21 ? 8'h02 : 8'h04);
      for (int m = 0; m < 4; m++) begin
        axi_wr(IDX_EQU_CHOP, {4'h0, 2'(m), 2'h0});
        for (int f = 0; f < 3; f++) run_frame(2'(m), f == 1);
      end
    end
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge CLK_SYS);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
